// file: dtm_pkg.sv
// dtm_pkg: register map, field positions, reset values and prescaler figures
// for the dual timer block; shared by the top and its prescaler.
package dtm_pkg;
	// ==========================================================
	// register byte offsets (low 12 address bits)
	localparam logic [11:0] ADDR_MODE     = 12'h400;
	localparam logic [11:0] ADDR_CONTROL  = 12'h410;
	localparam logic [11:0] ADDR_COUNT0   = 12'h420;
	localparam logic [11:0] ADDR_COUNT1   = 12'h424;
	localparam logic [11:0] ADDR_RELOAD0  = 12'h428;
	localparam logic [11:0] ADDR_RELOAD1  = 12'h42C;
	localparam logic [11:0] ADDR_SYSCFG   = 12'h430;
	localparam logic [11:0] ADDR_OUTSTAT  = 12'h434;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h440;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h444;
	// ==========================================================
	// timer_control bit positions
	localparam int CTL_TF1 = 7;
	localparam int CTL_TR1 = 6;
	localparam int CTL_TF0 = 5;
	localparam int CTL_TR0 = 4;
	localparam int CTL_IE1 = 3;
	localparam int CTL_IT1 = 2;
	localparam int CTL_IE0 = 1;
	localparam int CTL_IT0 = 0;
	// timer_mode_register: per timer nibble {gate, counter select, mode pair}
	localparam int MODE_T1_LSB = 4;
	localparam int MODE_CT     = 2;
	localparam int MODE_GATE   = 3;
	// timer_output_status toggle enables
	localparam int OUT_TOG0 = 0;
	localparam int OUT_TOG1 = 2;
	// interrupt status bits
	localparam int IRQ_TF0 = 0;
	localparam int IRQ_TF1 = 1;
	localparam int IRQ_IE0 = 2;
	localparam int IRQ_IE1 = 3;
	// ==========================================================
	// mode pair encodings
	localparam logic [1:0] MODE_RELOAD16 = 2'h0;
	localparam logic [1:0] MODE_FREE16   = 2'h1;
	localparam logic [1:0] MODE_RELOAD8  = 2'h2;
	localparam logic [1:0] MODE_SPLIT    = 2'h3;
	// prescaler_select encodings and divide factors in clk_in cycles
	localparam logic [1:0] PRESC_DIV4  = 2'h0;
	localparam logic [1:0] PRESC_DIV16 = 2'h1;
	localparam logic [1:0] PRESC_DIV64 = 2'h2;
	localparam int         DIV_4       = 4;
	localparam int         DIV_16      = 16;
	localparam int         DIV_64      = 64;
	// ==========================================================
	// reset values
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  MODE_RESET    = 8'h00;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [1:0]  SYSCFG_RESET  = 2'h0;
	localparam logic [3:0]  IRQ_RESET     = 4'h0;
endpackage

// file: dtm_prescaler.sv
// dtm_prescaler: makes the one-cycle prescaled_timer_clock tick from clk_in.
// assumes clk_in is the oscillator and the select comes from a local register.
`timescale 1ns/1ns
module dtm_prescaler (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// divide select
	input  wire logic [1:0] select_in,
	// tick
	output logic            tick_out
);
	// ==========================================================
	// terminal count
	// reserved encoding falls back to the fastest rate rather than stopping
	function automatic logic [5:0] term_of(input logic [1:0] sel);
		case (sel)
			dtm_pkg::PRESC_DIV16: term_of = 6'(dtm_pkg::DIV_16 - 1);
			dtm_pkg::PRESC_DIV64: term_of = 6'(dtm_pkg::DIV_64 - 1);
			default:              term_of = 6'(dtm_pkg::DIV_4 - 1);
		endcase
	endfunction

	logic [5:0] count;

	// ==========================================================
	// divider; >= so a shorter select taken mid-count wraps at once
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count    <= 6'h00;
			tick_out <= 1'b0;
		end else if (count >= term_of(select_in)) begin
			count    <= 6'h00;
			tick_out <= 1'b1;
		end else begin
			count    <= count + 6'h01;
			tick_out <= 1'b0;
		end
	end
endmodule

// file: dtm_top.sv
// dtm_top: two 16-bit timer/counters with four modes, timer_control flags,
// external interrupt edge flags, AHB-Lite register slave and an interrupt line.
// assumes one clock, a single AHB-Lite master, pins asynchronous to clk_in.
//
// How it works
// - in mode 0 a timer counts 16 bits and on wrap sets its flag and reloads both bytes.
// - the 8-bit reload mode takes its reload value from the low reload byte.
// - mode 0 overflow period is prescale times (65536 minus reload) oscillator cycles.
// - in mode 1 a timer counts 16 bits freely with no reload.
// - in mode 2 only the low byte counts, reloads from the low reload byte, high untouched.
// - timer 1 in mode 3 holds its count as if its run bit were clear.
// - timer 0 in mode 3 runs its low byte as an 8-bit counter with timer 0 controls.
// - in that split mode the timer 0 high byte counts ticks under run_bit_one, sets flag one.
// - during the split, timer 1 runs outside mode 3 but never sets its own flag.
// - flag one is set on overflow unless its toggle enable is set, cleared by ack or write.
// - flag zero is set on overflow unless its toggle enable is set, cleared by ack or write.
// - the external interrupt edge flag is set on detection and cleared when processed.
// - the type bit picks falling edge or low level detection.
// - the tick is the clock divided by 4, 16 or 64 per the prescaler select.
// - each timer's mode comes from its mode pair in the mode register.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
module dtm_top (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// ahb-lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// pins
	input  wire logic [1:0]  external_irq_input_in,
	input  wire logic [1:0]  count_pin_in,
	// processor vectoring acks {ie1, ie0, tf1, tf0}
	input  wire logic [3:0]  irq_ack_in,
	// events out
	output logic             irq_out,
	output logic             timer0_overflow_out,
	output logic             timer1_overflow_out
);
	// ==========================================================
	// registers
	logic [7:0]  timer_mode_register;
	logic        overflow_flag_one, run_bit_one, overflow_flag_zero, run_bit_zero;
	logic        ext_irq_edge_flag_one, ext_irq_type_one;
	logic        ext_irq_edge_flag_zero, ext_irq_type_zero;
	logic [15:0] count0, count1, reload0, reload1;
	logic [1:0]  prescaler_select;
	logic        toggle_out_enable_zero, toggle_out_enable_one;
	logic [3:0]  irq_status, irq_mask;
	logic        wr_pend;
	logic [11:0] wr_addr;
	logic [3:0]  pin_meta, pin_sync, pin_prev;
	logic        prescaled_timer_clock;

	// ==========================================================
	// pin synchronisers: {ext1, ext0, count1, count0}
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_meta <= 4'hF;
			pin_sync <= 4'hF;
			pin_prev <= 4'hF;
		end else begin
			pin_meta <= {external_irq_input_in, count_pin_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	logic [3:0] pin_fall;
	assign pin_fall = pin_prev & ~pin_sync;

	dtm_prescaler u_presc (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.select_in (prescaler_select),
		.tick_out  (prescaled_timer_clock)
	);

	// ==========================================================
	// ahb-lite: zero wait, writes land in the data phase
	logic addr_ok;
	assign addr_ok = hsel_in && htrans_in[1] && hready_in;

	function automatic logic wr_hit(input logic pend, input logic [11:0] a,
		input logic [11:0] reg_addr);
		wr_hit = pend && (a == reg_addr);
	endfunction

	logic wr_mode, wr_ctl, wr_cnt0, wr_cnt1, wr_rel0, wr_rel1;
	logic wr_cfg, wr_out, wr_stat, wr_mask;
	assign wr_mode = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_MODE);
	assign wr_ctl  = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_CONTROL);
	assign wr_cnt0 = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_COUNT0);
	assign wr_cnt1 = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_COUNT1);
	assign wr_rel0 = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_RELOAD0);
	assign wr_rel1 = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_RELOAD1);
	assign wr_cfg  = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_SYSCFG);
	assign wr_out  = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_OUTSTAT);
	assign wr_stat = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_IRQ_STAT);
	assign wr_mask = wr_hit(wr_pend, wr_addr, dtm_pkg::ADDR_IRQ_MASK);

	logic [7:0]  control_view;
	logic [31:0] read_value;
	assign control_view = {overflow_flag_one, run_bit_one, overflow_flag_zero, run_bit_zero,
		ext_irq_edge_flag_one, ext_irq_type_one, ext_irq_edge_flag_zero, ext_irq_type_zero};

	always_comb begin
		case (haddr_in[11:0])
			dtm_pkg::ADDR_MODE:     read_value = {24'h000000, timer_mode_register};
			dtm_pkg::ADDR_CONTROL:  read_value = {24'h000000, control_view};
			dtm_pkg::ADDR_COUNT0:   read_value = {16'h0000, count0};
			dtm_pkg::ADDR_COUNT1:   read_value = {16'h0000, count1};
			dtm_pkg::ADDR_RELOAD0:  read_value = {16'h0000, reload0};
			dtm_pkg::ADDR_RELOAD1:  read_value = {16'h0000, reload1};
			dtm_pkg::ADDR_SYSCFG:   read_value = {30'h00000000, prescaler_select};
			dtm_pkg::ADDR_OUTSTAT:  read_value = {29'h00000000, toggle_out_enable_one,
				1'b0, toggle_out_enable_zero};
			dtm_pkg::ADDR_IRQ_STAT: read_value = {28'h0000000, irq_status};
			dtm_pkg::ADDR_IRQ_MASK: read_value = {28'h0000000, irq_mask};
			default:                read_value = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hreadyout_out <= 1'b0;
			hresp_out     <= 1'b0;
			hrdata_out    <= 32'h00000000;
			wr_pend       <= 1'b0;
			wr_addr       <= 12'h000;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			wr_pend       <= addr_ok && hwrite_in;
			if (addr_ok) begin
				wr_addr <= haddr_in[11:0];
			end
			if (addr_ok && !hwrite_in) begin
				hrdata_out <= read_value;
			end
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			timer_mode_register    <= dtm_pkg::MODE_RESET;
			reload0                <= dtm_pkg::COUNT_RESET;
			reload1                <= dtm_pkg::COUNT_RESET;
			prescaler_select       <= dtm_pkg::SYSCFG_RESET;
			toggle_out_enable_zero <= 1'b0;
			toggle_out_enable_one  <= 1'b0;
			irq_mask               <= dtm_pkg::IRQ_RESET;
		end else begin
			if (wr_mode) timer_mode_register <= hwdata_in[7:0];
			if (wr_rel0) reload0 <= hwdata_in[15:0];
			if (wr_rel1) reload1 <= hwdata_in[15:0];
			if (wr_cfg) prescaler_select <= hwdata_in[1:0];
			if (wr_out) begin
				toggle_out_enable_zero <= hwdata_in[dtm_pkg::OUT_TOG0];
				toggle_out_enable_one  <= hwdata_in[dtm_pkg::OUT_TOG1];
			end
			if (wr_mask) irq_mask <= hwdata_in[3:0];
		end
	end

	// ==========================================================
	// count enables and overflow detection
	logic [1:0] mode0, mode1;
	logic       split, inc0, inc0_high, inc1;
	logic       ovf0, ovf0_high, ovf1;
	assign mode0 = timer_mode_register[1:0];
	assign mode1 = timer_mode_register[dtm_pkg::MODE_T1_LSB +: 2];
	assign split = (mode0 == dtm_pkg::MODE_SPLIT);

	// gate lets the external interrupt pin hold the timer off while low
	assign inc0 = run_bit_zero
		&& (!timer_mode_register[dtm_pkg::MODE_GATE] || pin_sync[2])
		&& (timer_mode_register[dtm_pkg::MODE_CT] ? pin_fall[0] : prescaled_timer_clock);
	assign inc0_high = split && run_bit_one && prescaled_timer_clock;
	// during the split run_bit_one belongs to the timer 0 high byte: timer 1 runs on mode alone
	assign inc1 = (split || run_bit_one) && (mode1 != dtm_pkg::MODE_SPLIT)
		&& (!timer_mode_register[dtm_pkg::MODE_T1_LSB + dtm_pkg::MODE_GATE] || pin_sync[3])
		&& (timer_mode_register[dtm_pkg::MODE_T1_LSB + dtm_pkg::MODE_CT]
			? pin_fall[1] : prescaled_timer_clock);

	function automatic logic wraps(input logic [1:0] m, input logic [15:0] c);
		if (m == dtm_pkg::MODE_RELOAD16 || m == dtm_pkg::MODE_FREE16) begin
			wraps = (c == 16'hFFFF);
		end else begin
			wraps = (c[7:0] == 8'hFF);
		end
	endfunction

	assign ovf0      = inc0 && wraps(mode0, count0);
	assign ovf0_high = inc0_high && (count0[15:8] == 8'hFF);
	assign ovf1      = inc1 && wraps(mode1, count1);

	// ==========================================================
	// count step per mode
	function automatic logic [15:0] step(input logic [1:0] m, input logic [15:0] c,
		input logic [15:0] r);
		case (m)
			dtm_pkg::MODE_RELOAD16: step = (c == 16'hFFFF) ? r : c + 16'h0001;
			dtm_pkg::MODE_FREE16:   step = c + 16'h0001;
			dtm_pkg::MODE_RELOAD8:  step = {c[15:8],
				(c[7:0] == 8'hFF) ? r[7:0] : c[7:0] + 8'h01};
			default:                step = {c[15:8], c[7:0] + 8'h01};
		endcase
	endfunction

	logic [15:0] next_count0, next_count1;
	always_comb begin
		next_count0 = inc0 ? step(mode0, count0, reload0) : count0;
		if (inc0_high) begin
			next_count0[15:8] = count0[15:8] + 8'h01;
		end
		next_count1 = inc1 ? step(mode1, count1, reload1) : count1;
	end

	// a software write wins over a count in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count0 <= dtm_pkg::COUNT_RESET;
			count1 <= dtm_pkg::COUNT_RESET;
		end else begin
			count0 <= wr_cnt0 ? hwdata_in[15:0] : next_count0;
			count1 <= wr_cnt1 ? hwdata_in[15:0] : next_count1;
		end
	end

	// ==========================================================
	// timer_control flags: hardware set beats ack and software clear
	logic set_tf0, set_tf1, set_ie0, set_ie1;
	assign set_tf0 = ovf0 && !toggle_out_enable_zero;
	// during the split only the high byte of timer 0 may raise flag one
	assign set_tf1 = (split ? ovf0_high : ovf1) && !toggle_out_enable_one;
	assign set_ie0 = ext_irq_type_zero ? pin_fall[2] : !pin_sync[2];
	assign set_ie1 = ext_irq_type_one ? pin_fall[3] : !pin_sync[3];

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			{overflow_flag_one, run_bit_one, overflow_flag_zero, run_bit_zero,
				ext_irq_edge_flag_one, ext_irq_type_one, ext_irq_edge_flag_zero,
				ext_irq_type_zero} <= dtm_pkg::CONTROL_RESET;
		end else begin
			if (wr_ctl) begin
				run_bit_one       <= hwdata_in[dtm_pkg::CTL_TR1];
				run_bit_zero      <= hwdata_in[dtm_pkg::CTL_TR0];
				ext_irq_type_one  <= hwdata_in[dtm_pkg::CTL_IT1];
				ext_irq_type_zero <= hwdata_in[dtm_pkg::CTL_IT0];
			end
			if (set_tf0) overflow_flag_zero <= 1'b1;
			else if (irq_ack_in[dtm_pkg::IRQ_TF0]) overflow_flag_zero <= 1'b0;
			else if (wr_ctl) overflow_flag_zero <= hwdata_in[dtm_pkg::CTL_TF0];
			if (set_tf1) overflow_flag_one <= 1'b1;
			else if (irq_ack_in[dtm_pkg::IRQ_TF1]) overflow_flag_one <= 1'b0;
			else if (wr_ctl) overflow_flag_one <= hwdata_in[dtm_pkg::CTL_TF1];
			if (set_ie0) ext_irq_edge_flag_zero <= 1'b1;
			else if (irq_ack_in[dtm_pkg::IRQ_IE0]) ext_irq_edge_flag_zero <= 1'b0;
			else if (wr_ctl) ext_irq_edge_flag_zero <= hwdata_in[dtm_pkg::CTL_IE0];
			if (set_ie1) ext_irq_edge_flag_one <= 1'b1;
			else if (irq_ack_in[dtm_pkg::IRQ_IE1]) ext_irq_edge_flag_one <= 1'b0;
			else if (wr_ctl) ext_irq_edge_flag_one <= hwdata_in[dtm_pkg::CTL_IE1];
		end
	end

	// ==========================================================
	// sticky status, write one to clear; a new event beats the clear
	logic [3:0] events;
	assign events = {set_ie1, set_ie0, set_tf1, set_tf0};

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			irq_status          <= dtm_pkg::IRQ_RESET;
			irq_out             <= 1'b0;
			timer0_overflow_out <= 1'b0;
			timer1_overflow_out <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~(wr_stat ? hwdata_in[3:0] : 4'h0)) | events;
			// one cycle behind status: keeps the output straight off a flop
			irq_out             <= |(irq_status & irq_mask);
			// raw overflows, not gated by toggle enables, for baud use
			timer0_overflow_out <= ovf0;
			timer1_overflow_out <= ovf1;
		end
	end

	// ==========================================================
	// checks
	sequence s_wrap16_0;
		inc0 && count0 == 16'hFFFF && !wr_cnt0;
	endsequence

	sequence s_div4_quiet;
		(prescaler_select == dtm_pkg::PRESC_DIV4)[*4];
	endsequence

	AST_RELOAD16: assert property (@(posedge clk_in) disable iff (reset_in)
		s_wrap16_0 and mode0 == dtm_pkg::MODE_RELOAD16
		|=> count0 == $past(reload0) && overflow_flag_zero == !$past(toggle_out_enable_zero))
		else $error("mode 0 wrap did not reload both bytes");
	AST_FREE16: assert property (@(posedge clk_in) disable iff (reset_in)
		s_wrap16_0 and mode0 == dtm_pkg::MODE_FREE16 |=> count0 == 16'h0000)
		else $error("mode 1 wrap did not go to zero");
	AST_RELOAD8: assert property (@(posedge clk_in) disable iff (reset_in)
		inc0 && mode0 == dtm_pkg::MODE_RELOAD8 && count0[7:0] == 8'hFF && !wr_cnt0
		|=> count0 == {$past(count0[15:8]), $past(reload0[7:0])})
		else $error("mode 2 reload wrong");
	AST_T1_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		mode1 == dtm_pkg::MODE_SPLIT && !wr_cnt1 |=> count1 == $past(count1))
		else $error("timer 1 moved in mode 3");
	AST_SPLIT_HIGH: assert property (@(posedge clk_in) disable iff (reset_in)
		split && run_bit_one && prescaled_timer_clock && count0[15:8] == 8'hFF
		&& !toggle_out_enable_one && !wr_cnt0 |=> overflow_flag_one && count0[15:8] == 8'h00)
		else $error("split high byte overflow missed");
	AST_T1_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
		split && !overflow_flag_one && !ovf0_high && !wr_ctl |=> !overflow_flag_one)
		else $error("timer 1 raised its flag during split");
	AST_TF1_BLOCK: assert property (@(posedge clk_in) disable iff (reset_in)
		toggle_out_enable_one && !overflow_flag_one && !wr_ctl |=> !overflow_flag_one)
		else $error("flag one set while toggle enabled");
	AST_TF0_SET: assert property (@(posedge clk_in) disable iff (reset_in)
		ovf0 && !toggle_out_enable_zero |=> overflow_flag_zero && irq_status[dtm_pkg::IRQ_TF0])
		else $error("flag zero not set on overflow");
	AST_IE0_EDGE: assert property (@(posedge clk_in) disable iff (reset_in)
		ext_irq_type_zero && pin_fall[2] |=> ext_irq_edge_flag_zero ##1 1'b1)
		else $error("falling edge not flagged");
	AST_DIV4: assert property (@(posedge clk_in) disable iff (reset_in)
		prescaled_timer_clock ##1 s_div4_quiet |-> prescaled_timer_clock
		&& !$past(prescaled_timer_clock, 1) && !$past(prescaled_timer_clock, 2)
		&& !$past(prescaled_timer_clock, 3))
		else $error("divide by 4 tick spacing wrong");
endmodule

// file: dtm_top_bench.sv
// dtm_top_bench: self-checking bench for the dual timer block, driven over ahb-lite.
// assumes one slave; hready_in is looped back from hreadyout_out.
`timescale 1ns/1ns
module dtm_top_bench;
	// ==========================================================
	// signals
	logic        clk_in     = 1'b0;
	logic        reset_in   = 1'b1;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  ext_pin    = 2'h3;
	logic [1:0]  cnt_pin    = 2'h3;
	logic [3:0]  ack        = 4'h0;
	logic        irq;
	logic        ovf0;
	logic        ovf1;
	logic [31:0] rd;
	int          fail_count = 0;
	int          checked    = 0;
	int          per;
	always #10 clk_in = ~clk_in;
	dtm_top dtm_top_i (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
		.hresp_out(hresp), .external_irq_input_in(ext_pin), .count_pin_in(cnt_pin),
		.irq_ack_in(ack), .irq_out(irq), .timer0_overflow_out(ovf0),
		.timer1_overflow_out(ovf1));
	// ==========================================================
	// shared tasks
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int c);
		repeat (c) @(posedge clk_in);
	endtask
	// waits for hready at an edge; the bound stands in for a hung slave
	task wait_ready;
		int k;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	// entered just after an edge; returns at the edge that ends the data phase
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask
	// counts edges until an overflow pulse; k is the spacing seen
	task wait_ovf(input logic which, output int k);
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while ((which ? ovf1 : ovf0) !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task run0(input logic [7:0] mode, input logic [15:0] cnt);
		wr(dtm_pkg::ADDR_MODE, {24'h0, mode});
		wr(dtm_pkg::ADDR_COUNT0, {16'h0, cnt});
		wr(dtm_pkg::ADDR_CONTROL, 32'h10);
		wait_ovf(1'b0, per);
	endtask
	// ==========================================================
	// scenarios
	task s_reset;
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h0);
		rdchk(dtm_pkg::ADDR_MODE, 32'h0);
		rdchk(dtm_pkg::ADDR_COUNT0, 32'h0);
		rdchk(dtm_pkg::ADDR_IRQ_STAT, 32'h0);
		rdchk(12'h7F0, 32'h0);
		chk_bit(hresp, 1'b0);
	endtask
	task s_modes;
		wr(dtm_pkg::ADDR_IRQ_MASK, 32'h1);
		wr(dtm_pkg::ADDR_RELOAD0, 32'h1200);
		run0(8'h00, 16'hFFFE);
		bus(1'b0, dtm_pkg::ADDR_COUNT0, 32'h0);
		chk_reg(rd & 32'hFF00, 32'h1200);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h30);
		chk_bit(irq, 1'b1);
		wr(dtm_pkg::ADDR_CONTROL, 32'h0);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h0);
		wr(dtm_pkg::ADDR_IRQ_STAT, 32'h1);
		tick(2);
		chk_bit(irq, 1'b0);
		run0(8'h01, 16'hFFFE);
		bus(1'b0, dtm_pkg::ADDR_COUNT0, 32'h0);
		chk_reg(rd & 32'hFF00, 32'h0);
		wr(dtm_pkg::ADDR_RELOAD0, 32'h00F0);
		run0(8'h02, 16'h5AFE);
		bus(1'b0, dtm_pkg::ADDR_COUNT0, 32'h0);
		chk_reg(rd & 32'hFFF0, 32'h5AF0);
		wr(dtm_pkg::ADDR_CONTROL, 32'h0);
		wr(dtm_pkg::ADDR_OUTSTAT, 32'h1);
		run0(8'h00, 16'hFFFE);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h10);
		wr(dtm_pkg::ADDR_OUTSTAT, 32'h0);
		wr(dtm_pkg::ADDR_CONTROL, 32'h0);
	endtask
	// reload FFFE gives two ticks a period in mode 0 and in mode 2 alike
	task s_rate;
		int div;
		wr(dtm_pkg::ADDR_RELOAD0, 32'hFFFE);
		for (int m = 0; m < 4; m += 2) begin
			for (int p = 0; p < 4; p++) begin
				div = (p == 1) ? dtm_pkg::DIV_16 : (p == 2) ? dtm_pkg::DIV_64 : dtm_pkg::DIV_4;
				wr(dtm_pkg::ADDR_SYSCFG, 32'(p));
				run0(8'(m), 16'hFFFE);
				wait_ovf(1'b0, per);
				chk_reg(32'(per), 32'(2 * div));
				wr(dtm_pkg::ADDR_CONTROL, 32'h0);
			end
		end
		wr(dtm_pkg::ADDR_SYSCFG, 32'h0);
	endtask
	task s_split;
		wr(dtm_pkg::ADDR_MODE, 32'h03);
		wr(dtm_pkg::ADDR_COUNT0, 32'hFE00);
		wr(dtm_pkg::ADDR_CONTROL, 32'h40);
		tick(40);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'hC0);
		bus(1'b0, dtm_pkg::ADDR_COUNT0, 32'h0);
		chk_reg(rd & 32'hFF, 32'h0);
		ack <= 4'h2;
		@(posedge clk_in);
		ack <= 4'h0;
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h40);
		// run_bit_one clear: timer 1 must still run out of its own mode 3
		wr(dtm_pkg::ADDR_CONTROL, 32'h0);
		wr(dtm_pkg::ADDR_COUNT1, 32'hFFFE);
		wait_ovf(1'b1, per);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h00);
		wr(dtm_pkg::ADDR_MODE, 32'h30);
		wr(dtm_pkg::ADDR_CONTROL, 32'h40);
		wr(dtm_pkg::ADDR_COUNT1, 32'h1234);
		tick(40);
		rdchk(dtm_pkg::ADDR_COUNT1, 32'h1234);
		// timer 1 alone: toggle enable blocks flag one, a clear enable lets it set
		wr(dtm_pkg::ADDR_OUTSTAT, 32'h4);
		wr(dtm_pkg::ADDR_MODE, 32'h0);
		wr(dtm_pkg::ADDR_COUNT1, 32'hFFFE);
		wait_ovf(1'b1, per);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h40);
		wr(dtm_pkg::ADDR_OUTSTAT, 32'h0);
		wr(dtm_pkg::ADDR_COUNT1, 32'hFFFE);
		wait_ovf(1'b1, per);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'hC0);
		wr(dtm_pkg::ADDR_CONTROL, 32'h0);
		wr(dtm_pkg::ADDR_MODE, 32'h0);
	endtask
	task s_ext;
		wr(dtm_pkg::ADDR_CONTROL, 32'h05);
		ext_pin <= 2'h0;
		tick(8);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h0F);
		ack <= 4'hC;
		@(posedge clk_in);
		ack <= 4'h0;
		tick(2);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h05);
		wr(dtm_pkg::ADDR_CONTROL, 32'h00);
		tick(4);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h0A);
		ext_pin <= 2'h3;
		tick(8);
		wr(dtm_pkg::ADDR_CONTROL, 32'h00);
		rdchk(dtm_pkg::ADDR_CONTROL, 32'h00);
	endtask
	// counter select on timer 0: three falling edges on its count pin
	task s_count;
		wr(dtm_pkg::ADDR_MODE, 32'h04);
		wr(dtm_pkg::ADDR_COUNT0, 32'h0010);
		wr(dtm_pkg::ADDR_CONTROL, 32'h10);
		repeat (3) begin
			cnt_pin <= 2'h2;
			tick(4);
			cnt_pin <= 2'h3;
			tick(4);
		end
		tick(8);
		rdchk(dtm_pkg::ADDR_COUNT0, 32'h0013);
		// gate set: ext pin 0 low holds the count off, high lets it through
		wr(dtm_pkg::ADDR_MODE, 32'h0C);
		ext_pin <= 2'h2;
		tick(4);
		cnt_pin <= 2'h2;
		tick(4);
		cnt_pin <= 2'h3;
		tick(8);
		rdchk(dtm_pkg::ADDR_COUNT0, 32'h0013);
		ext_pin <= 2'h3;
		tick(4);
		cnt_pin <= 2'h2;
		tick(4);
		cnt_pin <= 2'h3;
		tick(8);
		rdchk(dtm_pkg::ADDR_COUNT0, 32'h0014);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		tick(16);
		reset_in <= 1'b0;
		tick(2);
		s_reset();
		s_modes();
		s_rate();
		s_split();
		s_ext();
		s_count();
		report_and_stop();
	end
endmodule
